// ===== logic/wct_pkg.sv
package wct_pkg;

    // register indices as printed; byte address is four times the index
    localparam logic [31:0] WCT_IDX_CONTROL   = 32'h008003EB;
    localparam logic [31:0] WCT_IDX_COUNT_HI  = 32'h008003EC;
    localparam logic [31:0] WCT_IDX_COUNT_LO  = 32'h008003EE;
    localparam logic [31:0] WCT_IDX_CAP3_HI   = 32'h008003F0;
    localparam logic [31:0] WCT_IDX_CAP3_LO   = 32'h008003F2;
    localparam logic [31:0] WCT_IDX_CAP2_HI   = 32'h008003F4;
    localparam logic [31:0] WCT_IDX_CAP2_LO   = 32'h008003F6;
    localparam logic [31:0] WCT_IDX_CAP1_HI   = 32'h008003F8;
    localparam logic [31:0] WCT_IDX_CAP1_LO   = 32'h008003FA;
    localparam logic [31:0] WCT_IDX_CAP0_HI   = 32'h008003FC;
    localparam logic [31:0] WCT_IDX_CAP0_LO   = 32'h008003FE;
    localparam logic [31:0] WCT_IDX_STEP      = 32'h00000002;

    // control register fields
    localparam int          WCT_SEL_LSB       = 8;
    localparam int          WCT_ENABLE_BIT    = 15;
    localparam logic [15:0] WCT_CONTROL_RESET = 16'h0000;
    localparam logic [15:0] WCT_CONTROL_MASK  = 16'h8F00;

    // count clock runs at clk divided by this plus one
    localparam logic [0:0]  WCT_DIV_LAST      = 1'h1;

    // axi response codes
    localparam logic [1:0]  WCT_RESP_OKAY     = 2'h0;
    localparam logic [1:0]  WCT_RESP_SLVERR   = 2'h2;

    function automatic logic [31:0] wct_byte_addr(input logic [31:0] idx);
        wct_byte_addr = {idx[29:0], 2'h0};
    endfunction

endpackage

// ===== logic/wct_wide_capture_timer.sv
`timescale 1ns/100ps

// What this block does
// - counter steps at half the clk rate
// - enable bit 15 starts 32-bit up-count
// - enable cleared stops and holds counter
// - four channels share one counter
// - bits 8-11 pick pin or event line
// - source event copies counter into capture
// - counter readable while running, undisturbed
// - counter shown as high and low halves
// - captures are 32-bit, read-only, writes ignored
// - no overflow flag or interrupt
// - pin events request external input interrupt when pin selected
// - write and capture together: capture old value
// - counter and captures undefined after reset
// - capture between high and low writes stores pre-write value
// - counter read returns value present at the last high-half read
module wct_wide_capture_timer
#(
    parameter int CHANNELS = 4
)
(
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    input  wire logic                  ce,
    input  wire logic [CHANNELS-1:0]   ext_pin_chan,
    input  wire logic [CHANNELS-1:0]   event_bus_line,
    output logic [CHANNELS-1:0]        external_input_interrupt,
    input  wire logic [31:0]           s_axi_awaddr,
    input  wire logic [2:0]            s_axi_awprot,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [31:0]           s_axi_araddr,
    input  wire logic [2:0]            s_axi_arprot,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready
);
    import wct_pkg::*;

    logic [15:0]          control_reg;
    logic [31:0]          counter_reg;
    logic [0:0]           div_reg;
    logic [15:0]          count_hi_stage_reg;
    logic [15:0]          count_lo_snap_reg;
    logic [31:0]          capture_reg [CHANNELS];
    logic [CHANNELS-1:0]  pin_s1_reg;
    logic [CHANNELS-1:0]  pin_s2_reg;
    logic [CHANNELS-1:0]  pin_s3_reg;
    logic [CHANNELS-1:0]  pin_level_reg;
    logic [CHANNELS-1:0]  pin_level_next;
    logic [CHANNELS-1:0]  line_prev_reg;
    logic [CHANNELS-1:0]  pin_event;
    logic [CHANNELS-1:0]  line_event;
    logic [CHANNELS-1:0]  src_event;
    logic [CHANNELS-1:0]  sel_line;
    logic                 count_enable_bit;
    logic                 count_tick;
    logic [31:0]          aw_addr_reg;
    logic                 aw_held_reg;
    logic [31:0]          w_data_reg;
    logic [3:0]           w_strb_reg;
    logic                 w_held_reg;
    logic                 wr_fire;
    logic                 wr_ctrl;
    logic                 wr_hi;
    logic                 wr_lo;
    logic                 wr_cap;
    logic                 ar_fire;
    logic [31:0]          rd_data;
    logic                 rd_hit;
    logic                 rd_is_hi;
    logic [15:0]          wr_ctrl_val;
    logic [15:0]          wr_half_val;

    assign count_enable_bit = control_reg[WCT_ENABLE_BIT];
    assign sel_line         = control_reg[WCT_SEL_LSB +: CHANNELS];

    // count clock is every second clk edge, phase held while stopped
    assign count_tick = count_enable_bit && (div_reg == WCT_DIV_LAST);

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            div_reg <= 1'h0;
        else if (ce && count_enable_bit)
            div_reg <= div_reg + 1'h1;
    end

    // three-stage pin synchroniser; first stage feeds only the second
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            pin_s1_reg <= '0;
            pin_s2_reg <= '0;
            pin_s3_reg <= '0;
        end
        else if (ce)
        begin
            pin_s1_reg <= ext_pin_chan;
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
        end
    end

    // a pin change counts only once stages two and three agree
    always_comb
    begin
        pin_level_next = pin_level_reg;
        for (int i = 0; i < CHANNELS; i++)
        begin
            if (pin_s2_reg[i] == pin_s3_reg[i])
                pin_level_next[i] = pin_s3_reg[i];
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            pin_level_reg <= '0;
            line_prev_reg <= '0;
        end
        else if (ce)
        begin
            pin_level_reg <= pin_level_next;
            line_prev_reg <= event_bus_line;
        end
    end

    // rising edges give one-cycle pulses, so a held level captures once
    assign pin_event  = pin_level_next & ~pin_level_reg;
    assign line_event = event_bus_line & ~line_prev_reg;
    assign src_event  = (sel_line & line_event) | (~sel_line & pin_event);

    // capture takes the counter as it stands before any same-cycle write;
    // no reset, contents are undefined until the first event
    always_ff @(posedge clk)
    begin
        if (ce)
        begin
            for (int i = 0; i < CHANNELS; i++)
            begin
                if (src_event[i])
                    capture_reg[i] <= counter_reg;
            end
        end
    end

    // interrupt request pulse on events taken from a pin
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            external_input_interrupt <= '0;
        else if (ce)
            external_input_interrupt <= pin_event & ~sel_line;
    end

    // axi write address and data are taken independently
    assign s_axi_awready = ce && !aw_held_reg && !s_axi_bvalid;
    assign s_axi_wready  = ce && !w_held_reg && !s_axi_bvalid;
    assign wr_fire       = ce && aw_held_reg && w_held_reg && !s_axi_bvalid;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= 32'h00000000;
        end
        else if (ce)
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            else if (wr_fire)
                aw_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            w_held_reg <= 1'b0;
            w_data_reg <= 32'h00000000;
            w_strb_reg <= 4'h0;
        end
        else if (ce)
        begin
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            else if (wr_fire)
                w_held_reg <= 1'b0;
        end
    end

    // write decode; capture addresses are mapped but take nothing
    assign wr_ctrl = wr_fire && (aw_addr_reg == wct_byte_addr(WCT_IDX_CONTROL));
    assign wr_hi   = wr_fire && (aw_addr_reg == wct_byte_addr(WCT_IDX_COUNT_HI));
    assign wr_lo   = wr_fire && (aw_addr_reg == wct_byte_addr(WCT_IDX_COUNT_LO));

    always_comb
    begin
        wr_cap = 1'b0;
        for (int i = 0; i < CHANNELS; i++)
        begin
            if (aw_addr_reg == wct_byte_addr(WCT_IDX_CAP0_HI - 32'(i) * 2 * WCT_IDX_STEP) ||
                aw_addr_reg == wct_byte_addr(WCT_IDX_CAP0_LO - 32'(i) * 2 * WCT_IDX_STEP))
                wr_cap = 1'b1;
        end
    end

    // byte enables merged into the low halfword
    always_comb
    begin
        wr_ctrl_val = control_reg;
        wr_half_val = counter_reg[15:0];
        if (w_strb_reg[0])
            wr_ctrl_val[7:0] = w_data_reg[7:0];
        if (w_strb_reg[1])
            wr_ctrl_val[15:8] = w_data_reg[15:8];
        wr_ctrl_val = wr_ctrl_val & WCT_CONTROL_MASK;
        if (w_strb_reg[0])
            wr_half_val[7:0] = w_data_reg[7:0];
        if (w_strb_reg[1])
            wr_half_val[15:8] = w_data_reg[15:8];
        if (!w_strb_reg[0])
            wr_half_val[7:0] = wr_lo ? counter_reg[7:0] : count_hi_stage_reg[7:0];
        if (!w_strb_reg[1])
            wr_half_val[15:8] = wr_lo ? counter_reg[15:8] : count_hi_stage_reg[15:8];
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            control_reg <= WCT_CONTROL_RESET;
        else if (ce && wr_ctrl)
            control_reg <= wr_ctrl_val;
    end

    // high half is staged so both halves land in one update
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            count_hi_stage_reg <= 16'h0000;
        else if (ce && wr_hi)
            count_hi_stage_reg <= wr_half_val;
    end

    // counter has no reset and no overflow flag; it just wraps
    always_ff @(posedge clk)
    begin
        if (ce)
        begin
            if (wr_lo)
                counter_reg <= {count_hi_stage_reg, wr_half_val};
            else if (count_tick)
                counter_reg <= counter_reg + 32'h00000001;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= WCT_RESP_OKAY;
        end
        else if (ce)
        begin
            if (wr_fire)
            begin
                s_axi_bvalid <= 1'b1;
                // writes to captures are silently dropped with okay
                s_axi_bresp  <= (wr_ctrl || wr_hi || wr_lo || wr_cap) ?
                                WCT_RESP_OKAY : WCT_RESP_SLVERR;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // read path; one read outstanding at a time
    assign s_axi_arready = ce && !s_axi_rvalid;
    assign ar_fire       = s_axi_arvalid && s_axi_arready;
    assign rd_is_hi      = (s_axi_araddr == wct_byte_addr(WCT_IDX_COUNT_HI));

    always_comb
    begin
        rd_data = 32'h00000000;
        rd_hit  = 1'b1;
        if (s_axi_araddr == wct_byte_addr(WCT_IDX_CONTROL))
            rd_data = {16'h0000, control_reg};
        else if (rd_is_hi)
            rd_data = {16'h0000, counter_reg[31:16]};
        else if (s_axi_araddr == wct_byte_addr(WCT_IDX_COUNT_LO))
            rd_data = {16'h0000, count_lo_snap_reg};
        else
        begin
            rd_hit = 1'b0;
            for (int i = 0; i < CHANNELS; i++)
            begin
                if (s_axi_araddr == wct_byte_addr(WCT_IDX_CAP0_HI - 32'(i) * 2 * WCT_IDX_STEP))
                begin
                    rd_data = {16'h0000, capture_reg[i][31:16]};
                    rd_hit  = 1'b1;
                end
                if (s_axi_araddr == wct_byte_addr(WCT_IDX_CAP0_LO - 32'(i) * 2 * WCT_IDX_STEP))
                begin
                    rd_data = {16'h0000, capture_reg[i][15:0]};
                    rd_hit  = 1'b1;
                end
            end
        end
    end

    // reading the high half freezes the low half, so a pair is coherent
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            count_lo_snap_reg <= 16'h0000;
        else if (ce && ar_fire && rd_is_hi)
            count_lo_snap_reg <= counter_reg[15:0];
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= WCT_RESP_OKAY;
        end
        else if (ce)
        begin
            if (ar_fire)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_data;
                s_axi_rresp  <= rd_hit ? WCT_RESP_OKAY : WCT_RESP_SLVERR;
            end
            else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

endmodule

// ===== test/test_wct_wide_capture_timer.sv
`timescale 1ns/100ps
module test_wct_wide_capture_timer;
    import wct_pkg::*;
    logic        clk, sys_rst, ce, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [3:0]  pin, line, irq, wstrb;
    logic [31:0] awaddr, wdata, araddr, rdata, rv, val;
    logic [1:0]  bresp, rresp, resp;
    int          fails, n_tests, cyc, irq_cnt [4];

    wct_event_source u_src (.clk(clk), .ext_pin_chan(pin), .event_bus_line(line));
    wct_wide_capture_timer #(.CHANNELS(4)) u_dut
    (
        .clk(clk), .sys_rst(sys_rst), .ce(ce), .ext_pin_chan(pin), .event_bus_line(line),
        .external_input_interrupt(irq), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready)
    );
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // hang guard and interrupt pulse tally
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        for (int i = 0; i < 4; i++)
            if (irq[i] === 1'b1)
                irq_cnt[i] <= irq_cnt[i] + 1;
        if (cyc == 6000)
        begin
            fails++;
            give_verdict;
        end
    end
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // address and data offered together, each dropped once taken
    task automatic wr(input logic [31:0] idx, input logic [31:0] d);
        awaddr <= idx << 2;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end
        while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [31:0] idx);
        araddr <= idx << 2;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (arready)
                arvalid <= 1'b0;
        end
        while (rvalid !== 1'b1);
        rv = rdata;
        resp = rresp;
        rready <= 1'b0;
        @(posedge clk);
    endtask
    // counter moves as one word, high half first
    task automatic cnt_set(input logic [31:0] v);
        wr(WCT_IDX_COUNT_HI, {16'h0000, v[31:16]});
        wr(WCT_IDX_COUNT_LO, {16'h0000, v[15:0]});
    endtask
    task automatic cnt_get;
        rd(WCT_IDX_COUNT_HI);
        val[31:16] = rv[15:0];
        rd(WCT_IDX_COUNT_LO);
        val[15:0] = rv[15:0];
    endtask
    task automatic cap_get(input int ch);
        rd(WCT_IDX_CAP0_HI - 32'(ch * 4));
        val[31:16] = rv[15:0];
        rd(WCT_IDX_CAP0_HI - 32'(ch * 4) + WCT_IDX_STEP);
        val[15:0] = rv[15:0];
    endtask
    task automatic t_regs;
        rd(WCT_IDX_CONTROL);
        chk("control reset", rv, 32'h0);
        wr(WCT_IDX_CONTROL, 32'hFFFF);
        rd(WCT_IDX_CONTROL);
        chk("control bits", rv, 32'h8F00);
        // byte strobes: only the enabled byte of control may change
        wstrb <= 4'h1;
        wr(WCT_IDX_CONTROL, 32'h0);
        rd(WCT_IDX_CONTROL);
        chk("low strobe only", rv, 32'h8F00);
        wstrb <= 4'h2;
        wr(WCT_IDX_CONTROL, 32'h0100);
        rd(WCT_IDX_CONTROL);
        chk("high strobe only", rv, 32'h0100);
        wstrb <= 4'hF;
        wr(WCT_IDX_CONTROL, 32'h0);
        rd(32'h008003ED);
        chk("unmapped read", {rv[29:0], resp}, 32'h2);
        wr(32'h008003ED, 32'h1);
        chk("unmapped write", 32'(resp), 32'(WCT_RESP_SLVERR));
    endtask
    task automatic t_count;
        int          s0;
        logic [31:0] v0;
        cnt_set(32'hFFFFFF00);
        repeat (20) @(posedge clk);
        cnt_get;
        chk("stopped count", val, 32'hFFFFFF00);
        wr(WCT_IDX_CONTROL, 32'h8000);
        s0 = cyc;
        cnt_get;
        v0 = val;
        repeat (600) @(posedge clk);
        // even spacing makes the half-rate count exact
        if ((cyc - s0) % 2 != 0)
            @(posedge clk);
        s0 = cyc - s0;
        cnt_get;
        chk("count rate", val - v0, 32'(s0 / 2));
        chk("wrapped", 32'(val < 32'h200), 32'h1);
        chk("no wrap irq", 32'(irq_cnt.sum()), 32'h0);
        // frozen edges neither count nor accept requests
        s0 = cyc;
        cnt_get;
        v0 = val;
        ce <= 1'b0;
        repeat (40) @(posedge clk);
        chk("frozen ready", 32'({awready, wready, arready}), 32'h0);
        ce <= 1'b1;
        if ((cyc - s0) % 2 != 0)
            @(posedge clk);
        s0 = cyc - s0 - 40;
        cnt_get;
        chk("frozen count", val - v0, 32'(s0 / 2));
        wr(WCT_IDX_CONTROL, 32'h0);
        cnt_get;
        v0 = val;
        repeat (40) @(posedge clk);
        cnt_get;
        chk("held count", val, v0);
    endtask
    task automatic t_line;
        wr(WCT_IDX_CONTROL, 32'h0F00);
        for (int c = 0; c < 4; c++)
        begin
            cnt_set(32'hA5A50000 + 32'(c));
            u_src.line_pulse(c);
        end
        for (int c = 0; c < 4; c++)
        begin
            cap_get(c);
            chk("line capture", val, 32'hA5A50000 + 32'(c));
        end
        wr(WCT_IDX_CAP0_HI, 32'h1234);
        cap_get(0);
        chk("capture read only", {val[29:0], resp}, 32'h96940000);
        // event lands on the edge that commits a counter write
        cnt_set(32'h0000C0DE);
        wr(WCT_IDX_COUNT_HI, 32'h0000BEEF);
        fork
            wr(WCT_IDX_COUNT_LO, 32'h00001234);
            begin
                @(posedge clk);
                u_src.line_pulse(1);
            end
        join
        cap_get(1);
        chk("capture on write", val, 32'h0000C0DE);
        cnt_get;
        chk("write wins", val, 32'hBEEF1234);
    endtask
    task automatic t_pin;
        wr(WCT_IDX_CONTROL, 32'h0);
        cnt_set(32'h11110000);
        u_src.line_pulse(2);
        cap_get(2);
        chk("line ignored", val, 32'hA5A50002);
        for (int c = 0; c < 4; c++)
        begin
            cnt_set(32'h5A5A0000 + 32'(c));
            u_src.pin_pulse(c);
            cap_get(c);
            chk("pin capture", val, 32'h5A5A0000 + 32'(c));
            chk("pin irq", 32'(irq_cnt[c]), 32'h1);
        end
        wr(WCT_IDX_CONTROL, 32'h0F00);
        u_src.pin_pulse(0);
        cap_get(0);
        chk("pin ignored", val, 32'h5A5A0000);
        chk("pin ignored irq", 32'(irq_cnt[0]), 32'h1);
    endtask
    initial
    begin
        sys_rst = 1'b1;
        ce = 1'b1;
        wstrb = 4'hF;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, wdata, araddr} = '0;
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        t_regs;
        t_count;
        t_line;
        t_pin;
        give_verdict;
    end
endmodule

// ===== test/wct_checker_properties.sv
`timescale 1ns/100ps
module wct_checker
#(
    parameter int CHANNELS = 4
)
(
    input wire logic                clk,
    input wire logic                sys_rst,
    input wire logic                ce,
    input wire logic [CHANNELS-1:0] ext_pin_chan,
    input wire logic [CHANNELS-1:0] external_input_interrupt,
    input wire logic                s_axi_awready,
    input wire logic                s_axi_wready,
    input wire logic [1:0]          s_axi_bresp,
    input wire logic                s_axi_bvalid,
    input wire logic                s_axi_bready,
    input wire logic                s_axi_arready,
    input wire logic [31:0]         s_axi_rdata,
    input wire logic [1:0]          s_axi_rresp,
    input wire logic                s_axi_rvalid,
    input wire logic                s_axi_rready
);
    import wct_pkg::*;
    wire logic [CHANNELS-1:0] irq = external_input_interrupt;
    default clocking dc @(posedge clk); endclocking
    default disable iff (sys_rst);
    // answers stand until taken
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer changed");
    // one transfer each way at a time, none while frozen
    AST_R_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    AST_B_BLOCK: assert property (s_axi_bvalid |-> !(s_axi_awready || s_axi_wready))
        else $error("write taken while answer pending");
    AST_FROZEN: assert property (!ce |-> !(s_axi_awready || s_axi_wready || s_axi_arready))
        else $error("bus accepted while frozen");
    // halves sit in the low 16 bits, errors carry no data
    AST_HALVES: assert property (s_axi_rvalid && s_axi_rresp == WCT_RESP_OKAY
        |-> s_axi_rdata[31:16] == 16'h0000) else $error("upper read bits set");
    AST_ERR_ZERO: assert property (s_axi_rvalid && s_axi_rresp != WCT_RESP_OKAY
        |-> s_axi_rdata == 32'h0) else $error("error read with data");
    // interrupt is a lone pulse and only after a pin went high
    AST_IRQ_PULSE: assert property (|irq |=> (irq & $past(irq)) == '0)
        else $error("interrupt longer than one cycle");
    AST_IRQ_PIN: assert property (|irq |-> (irq & ~$past(ext_pin_chan, 3)) == '0)
        else $error("interrupt without pin event");
    C_IRQ: cover property (|irq);
    C_ERR: cover property (s_axi_bvalid && s_axi_bresp == WCT_RESP_SLVERR);
    C_READ: cover property (s_axi_rvalid && s_axi_rready);
endmodule

bind wct_wide_capture_timer wct_checker #(.CHANNELS(CHANNELS)) u_chk
(
    .clk(clk), .sys_rst(sys_rst), .ce(ce), .ext_pin_chan(ext_pin_chan),
    .external_input_interrupt(external_input_interrupt), .s_axi_awready(s_axi_awready),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);

// ===== test/wct_event_source.sv
`timescale 1ns/100ps
module wct_event_source
(
    input wire logic  clk,
    output logic [3:0] ext_pin_chan,
    output logic [3:0] event_bus_line
);
    // pins and lines idle low
    initial
    begin
        ext_pin_chan = 4'h0;
        event_bus_line = 4'h0;
    end
    // pin held long enough to cross the synchroniser
    task automatic pin_pulse(input int ch);
        ext_pin_chan[ch] <= 1'b1;
        repeat (10) @(posedge clk);
        ext_pin_chan[ch] <= 1'b0;
        repeat (10) @(posedge clk);
    endtask
    // lines share clk, one cycle is a whole event
    task automatic line_pulse(input int ch);
        event_bus_line[ch] <= 1'b1;
        @(posedge clk);
        event_bus_line[ch] <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
endmodule
